// file: dv/xbus_flash_page_decode_assertions.sv
// Checker for the slave bus joining bridge_ctrl and flash_page_glue.
// Assumes one clock and a synchronous active-high reset; inputs are interface signals and flash_page_glue ports.
module xbus_flash_page_decode_assertions
    import xbus_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [XB_ADDR_W-1:0]    addr,
    input wire logic                    ior_n,
    input wire logic                    iow_n,
    input wire logic                    memr_n,
    input wire logic                    memw_n,
    input wire logic [GCS_N-1:0]        gcs_n,
    input wire logic [MCS_N-1:0]        mcs_n,
    input wire logic                    flash_we,
    input wire logic                    data_d2h_oe,
    input wire logic [31:0]             sys_addr,
    input wire logic [XB_ADDR_W-1:0]    slave_addr,
    input wire logic [3:0]              slave_strb_n,
    input wire logic [DEV_SEL_N-1:0]    dev_sel_n,
    input wire logic                    bdata_oe_n,
    input wire logic [FLASH_ADDR_W-1:0] flash_addr,
    input wire logic                    flash_in_window,
    input wire logic                    program_voltage_enable_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------------------
    // Slave-bus relations, all in the one clock domain
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_buffer_enable: assert property (1 |=> bdata_oe_n == &$past(mcs_n))
        else $error("memory buffer enable does not follow the memory selects");
    chk_addr_copy: assert property (1 |=> slave_addr == $past(addr)
        && slave_strb_n == $past({ior_n, iow_n, memr_n, memw_n}))
        else $error("buffered address or strobes wrong");
    chk_dev_select: assert property (1 |=> dev_sel_n == ($past(gcs_n[0])
        ? 16'hFFFF : ~(16'h0001 << $past(addr[3:0]))))
        else $error("device select does not match shared select and address");
    chk_io_select: assert property (!ior_n || !iow_n |-> !(&gcs_n))
        else $error("I/O strobe without a chip select");
    chk_mem_select: assert property (!memr_n || !memw_n |-> !(&mcs_n))
        else $error("memory strobe without a memory select");
    chk_read_drive: assert property (data_d2h_oe |-> !$past(ior_n))
        else $error("read data driven outside an I/O read");
    // Three cycles allow for the registered gate behind the write enable.
    chk_vpen_gate: assert property (!flash_we [*3] |-> program_voltage_enable_low)
        else $error("programming voltage without flash write enable");
    chk_window_flag: assert property (1 |=> flash_in_window ==
        ($past(sys_addr) >= WIN_BASE && $past(sys_addr) <= WIN_LAST))
        else $error("window flag wrong for memory address");
    chk_flash_low: assert property (1 |=> flash_addr[16:0] == $past(sys_addr[16:0]))
        else $error("low flash address not taken from the cycle");
    chk_reset_idle: assert property ($fell(rst) |-> program_voltage_enable_low && &dev_sel_n)
        else $error("outputs not idle after reset");
    cover property (!memw_n && !mcs_n[MCS_FLASH]);
    cover property (!program_voltage_enable_low);
    cover property (!iow_n && addr == CTL_IO_ADDR);
endmodule

// file: dv/xbus_flash_page_decode_tb_top.sv
// Testbench: bridge_ctrl and flash_page_glue joined by one xbus_if, driven over Avalon-MM.
// Assumes the command map and slave-bus timing given in the package.
module xbus_flash_page_decode_tb_top
    import xbus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] WR   = 32'h80000000;
    localparam logic [31:0] CTL  = 32'h00100000 | 32'(CTL_IO_ADDR);
    localparam logic [31:0] MEMF = 32'h40100000;
    logic                    clk, rst, avs_read, avs_write, avs_waitrequest;
    logic                    bank_jumper, vpp_jumper, bdata_oe_n, flash_in_window;
    logic                    program_voltage_enable_low, vlow, bdseen;
    logic [3:0]              avs_address, slave_strb_n, trigger_bits;
    logic [31:0]             avs_writedata, avs_readdata, sys_addr;
    logic [XB_DATA_W-1:0]    slave_data;
    logic [XB_ADDR_W-1:0]    slave_addr;
    logic [DEV_SEL_N-1:0]    dev_sel_n, dsel;
    logic [FLASH_ADDR_W-1:0] flash_addr;
    int                      err_total, comparisons;
    xbus_if xb ();
    bridge_ctrl bridge_ctrl_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xb(xb));
    flash_page_glue flash_page_glue_inst (.clk(clk), .rst(rst), .xb(xb),
        .bank_jumper(bank_jumper), .vpp_jumper(vpp_jumper), .sys_addr(sys_addr),
        .slave_data(slave_data), .slave_addr(slave_addr), .slave_strb_n(slave_strb_n),
        .dev_sel_n(dev_sel_n), .bdata_oe_n(bdata_oe_n), .flash_addr(flash_addr),
        .flash_in_window(flash_in_window), .trigger_bits(trigger_bits),
        .program_voltage_enable_low(program_voltage_enable_low));
    xbus_flash_page_decode_assertions xbus_flash_page_decode_assertions_inst (.clk(clk),
        .rst(rst), .addr(xb.addr), .ior_n(xb.ior_n), .iow_n(xb.iow_n), .memr_n(xb.memr_n),
        .memw_n(xb.memw_n), .gcs_n(xb.gcs_n), .mcs_n(xb.mcs_n), .flash_we(xb.flash_we),
        .data_d2h_oe(xb.data_d2h_oe), .sys_addr(sys_addr), .slave_addr(slave_addr),
        .slave_strb_n(slave_strb_n), .dev_sel_n(dev_sel_n), .bdata_oe_n(bdata_oe_n),
        .flash_addr(flash_addr), .flash_in_window(flash_in_window),
        .program_voltage_enable_low(program_voltage_enable_low));
    // -------------------------------------------------------------------------
    // Bus tasks and checks
    // -------------------------------------------------------------------------
    // Selects stand only during a cycle and the voltage gate until the next command clears flash_we, so they are latched here.
    always @(posedge clk) begin
        if (dev_sel_n !== 16'hFFFF) dsel <= dev_sel_n;
        if (program_voltage_enable_low === 1'b0) vlow <= 1'b1;
        if (bdata_oe_n === 1'b0) bdseen <= 1'b1;
    end
    task automatic stop_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The request holds until waitrequest is seen low at a rising edge, then drops.
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            $display("mismatch at %0t: bus wait timed out", $time);
            stop_test();
        end
    endtask
    task automatic xcyc(input logic [31:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [31:0] q;
        int n;
        av(1'b1, AV_DATA_ADDR, {24'h000000, wd}, q);
        av(1'b1, AV_CMD_ADDR, cmd, q);
        n = 0;
        do begin
            av(1'b0, AV_STAT_ADDR, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        if (q[0] !== 1'b0) begin
            err_total++;
            $display("mismatch at %0t: slave cycle timed out", $time);
            stop_test();
        end
        av(1'b0, AV_RDAT_ADDR, 32'h0, q);
        rd = q[7:0];
    endtask
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic test_map();
        logic [7:0] v, rd;
        for (int s = 0; s < 8; s++) begin
            v = {s[2:0], 1'b0, ~s[3:0]};
            xcyc(WR | CTL, v, rd);
            xcyc(CTL, 8'h00, rd);
            chk(rd, v);
            chk(trigger_bits, 4'(~s[3:0]));
            sys_addr <= WIN_BASE + 32'h00002345 * 32'(s);
            repeat (3) @(posedge clk);
            chk(flash_addr, {s[2:0], sys_addr[16:0]});
            chk(flash_in_window, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            sys_addr <= i[0] ? WIN_LAST + 32'(i[1]) : WIN_BASE - 32'(i[1]);
            repeat (3) @(posedge clk);
            chk(flash_in_window, !i[1]);
        end
    endtask
    task automatic test_jumper();
        logic [7:0] rd;
        bank_jumper <= 1'b1;
        xcyc(WR | CTL, 8'h20, rd);
        repeat (4) @(posedge clk);
        xcyc(CTL, 8'h00, rd);
        chk(rd, 8'hA0);
        chk(flash_addr[19:17], 3'h5);
        bank_jumper <= 1'b0;
    endtask
    task automatic test_vpen();
        logic [10:0] t [6];
        logic [7:0] rd;
        t = '{11'h085, 11'h004, 11'h080, 11'h484, 11'h487, 11'h685};
        foreach (t[i]) begin
            vpp_jumper <= t[i][1];
            xcyc(WR | CTL, t[i][10:3], rd);
            repeat (4) @(posedge clk);
            vlow = 1'b0;
            xcyc(WR | MEMF | {2'h0, t[i][2], 29'h0}, 8'hC3, rd);
            chk(vlow, t[i][0]);
        end
        vpp_jumper <= 1'b0;
    endtask
    task automatic test_devsel();
        logic [7:0] rd;
        for (int i = 0; i < 16; i += 15) begin
            xcyc(WR | 32'(i), 8'h5A ^ 8'(i), rd);
            chk(dsel, 16'hFFFF ^ (16'h0001 << i));
            chk(slave_data, 8'h5A ^ 8'(i));
        end
        bdseen = 1'b0;
        xcyc(32'h40000100, 8'h00, rd);
        chk(bdseen, 1'b1);
    endtask
    task automatic test_reset();
        logic [31:0] q;
        logic [7:0] rd;
        av(1'b0, 4'h2, 32'h0, q);
        chk(q, UNMAPPED_READ);
        xcyc(WR | CTL, 8'hFF, rd);
        av(1'b0, AV_DATA_ADDR, 32'h0, q);
        chk(q, 32'h000000FF);
        av(1'b0, AV_CMD_ADDR, 32'h0, q);
        chk(q, WR | CTL);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xcyc(CTL, 8'h00, rd);
        chk(rd, 8'h00);
        chk(program_voltage_enable_low, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        bank_jumper = 1'b0;
        vpp_jumper = 1'b0;
        sys_addr = 32'h0;
        dsel = 16'hFFFF;
        vlow = 1'b0;
        bdseen = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_map();
        test_jumper();
        test_vpen();
        test_devsel();
        test_reset();
        stop_test();
    end
endmodule

// file: include/xbus_if.sv
// Interface joining the bridge-side controller to the flash page decode glue.
// Assumes both ends share clk; only the bus data lines are two-way.
interface xbus_if;
    import xbus_pkg::*;
    logic [XB_ADDR_W-1:0] addr;
    logic [XB_DATA_W-1:0] data_h2d;
    logic                 data_h2d_oe;
    logic [XB_DATA_W-1:0] data_d2h;
    logic                 data_d2h_oe;
    logic                 ior_n;
    logic                 iow_n;
    logic                 memr_n;
    logic                 memw_n;
    logic [GCS_N-1:0]     gcs_n;
    logic [MCS_N-1:0]     mcs_n;
    logic                 flash_we;
    modport bridge (output addr, data_h2d, data_h2d_oe, ior_n, iow_n, memr_n, memw_n,
                    gcs_n, mcs_n, flash_we, input data_d2h, data_d2h_oe);
    modport glue   (input addr, data_h2d, data_h2d_oe, ior_n, iow_n, memr_n, memw_n,
                    gcs_n, mcs_n, flash_we, output data_d2h, data_d2h_oe);
endinterface

// file: include/xbus_pkg.sv
// Package for the slave-bus flash page decode: register offsets, field positions,
// reset values and slave-bus widths shared by both ends.
// Assumes a single 200 MHz clock and a synchronous active-high reset everywhere.
package xbus_pkg;
    // -------------------------------------------------------------------------
    // Slave bus shape
    // -------------------------------------------------------------------------
    localparam int XB_DATA_W = 8;
    localparam int XB_ADDR_W = 17;
    localparam int GCS_N     = 3;
    localparam int DEV_SEL_N = 16;
    localparam int DEV_IDX_W = 4;
    // -------------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------------
    localparam int CTL_BANK_BIT = 7;
    localparam int CTL_SEC_HI   = 6;
    localparam int CTL_SEC_LO   = 5;
    localparam int CTL_VPP_BIT  = 4;
    localparam int CTL_TRIG_HI  = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Flash window in system memory space and flash address size.
    localparam logic [31:0] WIN_BASE = 32'h000E0000;
    localparam logic [31:0] WIN_LAST = 32'h000FFFFF;
    localparam int FLASH_ADDR_W = 20;
    // -------------------------------------------------------------------------
    // Slave-bus I/O address of the control register and the memory selects
    // -------------------------------------------------------------------------
    localparam logic [XB_ADDR_W-1:0] CTL_IO_ADDR = 17'h004D1;
    localparam int MCS_NVRAM = 0;
    localparam int MCS_FLASH = 1;
    localparam int MCS_N     = 2;
    // -------------------------------------------------------------------------
    // Controller registers on Avalon-MM (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [3:0] AV_CMD_ADDR  = 4'h0;
    localparam logic [3:0] AV_DATA_ADDR = 4'h4;
    localparam logic [3:0] AV_STAT_ADDR = 4'h8;
    localparam logic [3:0] AV_RDAT_ADDR = 4'hC;
    localparam int CMD_WRITE_BIT = 31;
    localparam int CMD_MEM_BIT   = 30;
    localparam int CMD_FWE_BIT   = 29;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    // Strobe width on the slave bus, in clock cycles.
    localparam int STROBE_NS     = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        XS_IDLE   = 2'b00,
        XS_STROBE = 2'b01,
        XS_DONE   = 2'b11
    } xfer_state_type;
endpackage

// file: logic/bridge_ctrl.sv
// Bridge-side end: takes slave-bus cycles from software over Avalon-MM and
// runs them with decoded chip selects and strobes of fixed width.
// Assumes the glue end answers I/O reads within the strobe.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
module bridge_ctrl
    import xbus_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic [3:0]     avs_address,
    input  wire logic           avs_read,
    input  wire logic           avs_write,
    input  wire logic [31:0]    avs_writedata,
    output logic [31:0]         avs_readdata,
    output logic                avs_waitrequest,
    xbus_if.bridge              xb
);
    typedef struct packed {
        xfer_state_type         st;
        logic [7:0]             cnt;
        logic [31:0]            cmd;
        logic [7:0]             wdat;
        logic [7:0]             rdat;
        logic                   fwe;
        logic [31:0]            rd;
        logic                   wait_n;
        logic [XB_ADDR_W-1:0]   addr;
        logic                   oe;
        logic [3:0]             strb_n;
        logic [GCS_N-1:0]       gcs_n;
        logic [MCS_N-1:0]       mcs_n;
    } bridge_state_type;

    bridge_state_type state_q;
    bridge_state_type state_d;
    logic             is_mem;
    logic             is_wr;

    assign is_mem = state_q.cmd[CMD_MEM_BIT];
    assign is_wr  = state_q.cmd[CMD_WRITE_BIT];

    always_comb begin
        state_d = state_q;
        state_d.wait_n = 1'b0;
        if ((avs_read || avs_write) && !state_q.wait_n) begin
            state_d.wait_n = 1'b1;
            if (avs_write) begin
                case (avs_address)
                    AV_CMD_ADDR: begin
                        state_d.cmd = avs_writedata;
                        state_d.fwe = avs_writedata[CMD_FWE_BIT];
                        state_d.st  = XS_STROBE;
                        state_d.cnt = 8'(STROBE_CYC);
                    end
                    AV_DATA_ADDR: state_d.wdat = avs_writedata[7:0];
                    default: ;
                endcase
            end else begin
                case (avs_address)
                    AV_DATA_ADDR: state_d.rd = {24'h000000, state_q.wdat};
                    AV_STAT_ADDR: state_d.rd = {31'h00000000, state_q.st != XS_IDLE};
                    AV_RDAT_ADDR: state_d.rd = {24'h000000, state_q.rdat};
                    AV_CMD_ADDR:  state_d.rd = state_q.cmd;
                    default:      state_d.rd = UNMAPPED_READ;
                endcase
            end
        end
        state_d.strb_n = 4'hF;
        state_d.gcs_n  = '1;
        state_d.mcs_n  = '1;
        state_d.oe     = 1'b0;
        case (state_q.st)
            XS_IDLE: ;
            XS_STROBE: begin
                state_d.addr = state_q.cmd[XB_ADDR_W-1:0];                        // RL2
                state_d.oe   = is_wr;
                state_d.strb_n = {is_mem | is_wr, is_mem | !is_wr,
                                  !is_mem | is_wr, !is_mem | !is_wr};            // RL2
                if (is_mem) begin
                    state_d.mcs_n[state_q.cmd[MCS_FLASH+19]] = 1'b0;              // RL6
                end else begin
                    state_d.gcs_n[state_q.cmd[21:20]] = 1'b0;                     // RL3
                end
                if (xb.data_d2h_oe) begin
                    state_d.rdat = xb.data_d2h;
                end
                state_d.cnt = state_q.cnt - 8'h01;
                if (state_q.cnt == 8'h00) begin
                    state_d.st = XS_DONE;
                end
            end
            XS_DONE: state_d.st = XS_IDLE;
            default: state_d.st = XS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q        <= '0;
            state_q.st     <= XS_IDLE;
            state_q.strb_n <= 4'hF;
            state_q.gcs_n  <= '1;
            state_q.mcs_n  <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_readdata    = state_q.rd;
    assign avs_waitrequest = !state_q.wait_n;
    assign xb.addr         = state_q.addr;
    assign xb.data_h2d     = state_q.wdat;
    assign xb.data_h2d_oe  = state_q.oe;
    assign xb.ior_n        = state_q.strb_n[3];
    assign xb.iow_n        = state_q.strb_n[2];
    assign xb.memr_n       = state_q.strb_n[1];
    assign xb.memw_n       = state_q.strb_n[0];
    assign xb.gcs_n        = state_q.gcs_n;
    assign xb.mcs_n        = state_q.mcs_n;
    assign xb.flash_we     = state_q.fwe;
endmodule

// file: logic/flash_page_glue.sv
// Slave-bus glue: buffers the low data byte and address, splits a shared chip
// select into device selects, enables the private memory buffer, maps a flash
// section into the upper memory window and gates programming voltage.
// Assumes the bridge end decodes and strobes; jumper pins are asynchronous.
//
// Summary of operation
// RL1: buffer 8 data, 17 address bits, strobes
// RL2: bridge decodes and drives chip selects, strobes
// RL3: bridge sets select ranges via base, mask; bridge_ctrl picks the select from command bits 21:20 instead
// RL4: split shared select zero into device selects
// RL5: memory buffer enable is OR of selects
// RL6: bridge alone controls configuration memory access
// RL7: only one 128 KB of eight sections visible
// RL8: control bit 7 selects flash bank
// RL9: bits 6,5 pick quarter within bank
// RL10: upper flash address from stored section bits
// RL11: bank jumper forces bank select to one
// RL12: programming needs bridge write enable and bit 4
// RL13: failsafe region also needs voltage jumper
// RL14: section appears at E0000h through FFFFFh
// RL15: low four bits stored apart as trigger
// RL16: reset clears section and voltage bits
// RL17: control register reads back effective bank
module flash_page_glue
    import xbus_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    xbus_if.glue                         xb,
    input  wire logic                    bank_jumper,
    input  wire logic                    vpp_jumper,
    input  wire logic [31:0]             sys_addr,
    output logic [XB_DATA_W-1:0]         slave_data,
    output logic [XB_ADDR_W-1:0]         slave_addr,
    output logic [3:0]                   slave_strb_n,
    output logic [DEV_SEL_N-1:0]         dev_sel_n,
    output logic                         bdata_oe_n,
    output logic [FLASH_ADDR_W-1:0]      flash_addr,
    output logic                         flash_in_window,
    output logic                         program_voltage_enable_low,
    output logic [3:0]                   trigger_bits
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                 bank_sync;
        logic [1:0]                 vpp_sync;
        logic [3:0]                 flash_ctl;
        logic [3:0]                 trig;
        logic [XB_DATA_W-1:0]       sdata;
        logic [XB_ADDR_W-1:0]       saddr;
        logic [3:0]                 strb_n;
        logic [DEV_SEL_N-1:0]       dsel_n;
        logic                       boe_n;
        logic [FLASH_ADDR_W-1:0]    faddr;
        logic                       in_win;
        logic                       vpen_n;
        logic [XB_DATA_W-1:0]       rdata;
        logic                       rd_oe;
        logic                       iow_n_prev;
    } glue_state_type;

    glue_state_type state_q;
    glue_state_type state_d;

    logic       bank_eff;
    logic       ctl_hit;
    logic [7:0] ctl_read;

    // Jumpers pass two flops; only the second stage is read.
    assign bank_eff = state_q.flash_ctl[CTL_BANK_BIT-4] | state_q.bank_sync[1];  // RL11
    assign ctl_hit  = (xb.addr == CTL_IO_ADDR);
    assign ctl_read = {bank_eff, state_q.flash_ctl[2:0], state_q.trig};          // RL17

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.bank_sync = {state_q.bank_sync[0], bank_jumper};
        state_d.vpp_sync  = {state_q.vpp_sync[0], vpp_jumper};
        state_d.sdata  = xb.data_h2d_oe ? xb.data_h2d : state_q.sdata;            // RL1
        state_d.saddr  = xb.addr;                                                 // RL1
        state_d.strb_n = {xb.ior_n, xb.iow_n, xb.memr_n, xb.memw_n};              // RL1
        state_d.dsel_n = '1;
        if (!xb.gcs_n[0]) begin
            state_d.dsel_n[xb.addr[DEV_IDX_W-1:0]] = 1'b0;                       // RL4
        end
        state_d.boe_n = &xb.mcs_n;                                                // RL5
        state_d.iow_n_prev = xb.iow_n;
        // Write on the rising edge of the write strobe, when data is settled.
        if (ctl_hit && xb.iow_n && !state_q.iow_n_prev) begin
            state_d.flash_ctl = state_q.sdata[CTL_BANK_BIT:CTL_VPP_BIT];
            state_d.trig      = state_q.sdata[CTL_TRIG_HI:0];                     // RL15
        end
        state_d.rd_oe = ctl_hit && !xb.ior_n;
        state_d.rdata = ctl_read;                                                 // RL17
        state_d.faddr = {bank_eff, state_q.flash_ctl[CTL_SEC_HI-4:CTL_SEC_LO-4],
                         sys_addr[XB_ADDR_W-1:0]};                                // RL7 RL8 RL9 RL10
        state_d.in_win = (sys_addr >= WIN_BASE) && (sys_addr <= WIN_LAST);        // RL14
        // Voltage only with software enable, bridge write enable and, for the
        // failsafe quarters, the jumper; the three-way gate keeps accidents out.
        state_d.vpen_n = !(state_q.flash_ctl[CTL_VPP_BIT-4] && xb.flash_we &&
                           (!(bank_eff && !state_q.flash_ctl[CTL_SEC_HI-4]) ||
                            state_q.vpp_sync[1]));                                // RL12 RL13
    end

    // -------------------------------------------------------------------------
    // Register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q        <= '0;
            state_q.strb_n <= 4'hF;
            state_q.dsel_n <= '1;
            state_q.boe_n  <= 1'b1;
            state_q.vpen_n <= 1'b1;
            state_q.iow_n_prev <= 1'b1;
            state_q.flash_ctl <= CTL_RESET[CTL_BANK_BIT:CTL_VPP_BIT];             // RL16
            state_q.trig   <= CTL_RESET[CTL_TRIG_HI:0];
        end else begin
            state_q <= state_d;
        end
    end

    assign xb.data_d2h                = state_q.rdata;
    assign xb.data_d2h_oe             = state_q.rd_oe;
    assign slave_data                 = state_q.sdata;
    assign slave_addr                 = state_q.saddr;
    assign slave_strb_n               = state_q.strb_n;
    assign dev_sel_n                  = state_q.dsel_n;
    assign bdata_oe_n                 = state_q.boe_n;
    assign flash_addr                 = state_q.faddr;
    assign flash_in_window            = state_q.in_win;
    assign program_voltage_enable_low = state_q.vpen_n;
    assign trigger_bits               = state_q.trig;
endmodule
